// ---- design/tcc_edge_detect.sv ----
// Synchroniser and selectable edge detector for the external capture input.
`timescale 1ns/100ps
module tcc_edge_detect
  import tcc_pkg::*;
(
  input  wire logic      sys_clk,    // System clock.
  input  wire logic      srst,       // Synchronous reset, active high.
  input  wire logic      pin_in,     // Asynchronous edge input pin.
  input  wire tcc_edge_e edge_sel,   // Which edges count.
  output logic           edge_pulse  // One-cycle valid edge.
);

  typedef struct packed {
    logic meta;   // First synchroniser stage.
    logic sync;   // Second synchroniser stage.
    logic prev;   // Previous synchronised level.
  } tcc_edge_s;

  tcc_edge_s s;
  tcc_edge_s next_s;

  // The first stage feeds only the second stage, so no logic sees a metastable level.
  always_comb begin
    next_s      = s;
    next_s.meta = pin_in;
    next_s.sync = s.meta;
    next_s.prev = s.sync;
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  // Edge decode runs on the synchronised pair only.
  // (R10) Edge selection decode.
  always_comb begin
    unique case (edge_sel)
      TCC_EDGE_FALL: edge_pulse = ~s.sync & s.prev;
      TCC_EDGE_RISE: edge_pulse = s.sync & ~s.prev;
      TCC_EDGE_BOTH: edge_pulse = s.sync ^ s.prev;
      TCC_EDGE_ALSO: edge_pulse = s.sync ^ s.prev;
    endcase
  end

endmodule

// ---- design/tcc_pkg.sv ----
// Shared constants, types and configuration carrier of the 16-bit compare/capture timer.
package tcc_pkg;

  // System clock rate and the count clock divider.
  localparam int unsigned SYS_CLK_HZ   = 100_000_000;
  localparam int unsigned PRESCALE_DIV = 8;
  localparam int unsigned PRESC_W      = $clog2(PRESCALE_DIV);
  localparam logic [PRESC_W-1:0] PRESC_LAST = PRESC_W'(PRESCALE_DIV - 1);
  localparam logic [PRESC_W-1:0] PRESC_RST  = 3'h0;

  // Counter geometry and reset values.
  localparam int unsigned CNT_W    = 16;
  localparam logic [CNT_W-1:0] CNT_ZERO = 16'h0000;
  localparam logic [CNT_W-1:0] CNT_ONE  = 16'h0001;
  localparam logic [CNT_W-1:0] CNT_MAX  = 16'hffff;
  localparam logic [CNT_W-1:0] CAP_RST  = 16'h0000;

  // Output pins idle high after reset, matching a disabled output with low active level bit.
  localparam logic WAVE_RST = 1'b1;

  // Output mode codes, {out_mode_hi, out_mode_lo}.
  localparam logic [1:0] MODE_TOGGLE   = 2'h0;
  localparam logic [1:0] MODE_PWM_A    = 2'h1;
  localparam logic [1:0] MODE_PWM_AB   = 2'h2;
  localparam logic [1:0] MODE_PPG_A    = 2'h3;

  // Capture edge selection.
  typedef enum logic [1:0] {
    TCC_EDGE_FALL = 2'h0,
    TCC_EDGE_RISE = 2'h1,
    TCC_EDGE_BOTH = 2'h2,
    TCC_EDGE_ALSO = 2'h3
  } tcc_edge_e;

  // Output and clear configuration, held by software outside the block.
  typedef struct packed {
    logic auto_clear_on_period;  // Period match clears the counter.
    logic out_mode_hi;           // Output mode, high bit.
    logic out_mode_lo;           // Output mode, low bit.
    logic output_enable_a;       // Output A follows its waveform.
    logic active_level_a;        // Output A level select.
    logic output_enable_b;       // Output B follows its waveform.
    logic active_level_b;        // Output B level select.
  } tcc_cfg_s;

endpackage

// ---- design/tcc_timer16.sv ----
// 16-bit up-counter with two compares, one capture and a two-pin output control circuit.
//
// Operation
// (R01) Clear cause zeroes counter on next tick.
// (R02) Counter holds value until that tick.
// (R03) Run low stops, clears on next tick.
// (R04) Rerun before clear: clear and count together.
// (R05) Rerun after clear: count from zero.
// (R06) Compare equality gives match and interrupt.
// (R07) Period match auto-clear makes interval timer.
// (R08) Software loads compares before using them.
// (R09) Valid edge copies count into capture; the code copies only while count_run is high.
// (R10) Capture edge: rising, falling or both.
// (R11) Outputs driven by overflow and match events.
// (R12) Software routes pins to timer function.
// (R13) Mode bits choose toggle, PWM or PPG.
// (R14) Software avoids unlisted output configurations.
// (R15) Enabled output changes per selected mode.
// (R16) Disabled output tied to inverse level bit.
// (R17) Count clock is system clock over eight.
// (R18) Wrap from maximum sets sticky overflow flag.
// (R19) Run rising: clear first tick, then count.
// (R20) Run already set: no clear, keep counting.
// (R21) One match event per counter value.
`timescale 1ns/100ps
module tcc_timer16
  import tcc_pkg::*;
(
  input  wire logic             sys_clk,           // System clock, 100 MHz.
  input  wire logic             srst,              // Synchronous reset, active high.
  input  wire logic             count_run,         // Run bit, level.
  input  wire tcc_cfg_s         cfg,               // Output and clear configuration.
  input  wire logic [CNT_W-1:0] compare_a,         // Compare register for output A.
  input  wire logic [CNT_W-1:0] compare_period,    // Period compare register.
  input  wire tcc_edge_e        edge_select_reg,   // Capture edge selection.
  input  wire logic             edge_input,        // External capture pin, asynchronous.
  input  wire logic             overflow_clear,    // Software clear of the overflow flag.
  output logic [CNT_W-1:0]      main_counter,      // Running count.
  output logic [CNT_W-1:0]      capture_value,     // Last captured count.
  output logic                  overflow_flag,     // Sticky overflow flag.
  output logic                  match_a_irq,       // Compare A match pulse.
  output logic                  match_period_irq,  // Period match pulse.
  output logic                  capture_irq,       // Capture edge pulse.
  output logic                  wave_out_a,        // Timer output pin A.
  output logic                  wave_out_b         // Timer output pin B.
);

  typedef struct packed {
    logic [PRESC_W-1:0] presc;         // Count clock divider.
    logic               run_prev;      // Run bit one cycle ago.
    logic               clear_pend;    // Clear waits for the next tick.
    logic               clr_period;    // Pending clear came from a period match.
    logic               fresh;         // Counter took a new value last tick while running.
    logic [CNT_W-1:0]   counter;       // Count value.
    logic [CNT_W-1:0]   capture;       // Capture register.
    logic               ovf_flag;      // Sticky overflow flag.
    logic               irq_a;         // Compare A match pulse.
    logic               irq_p;         // Period match pulse.
    logic               irq_cap;       // Capture pulse.
    logic               st_a;          // Waveform state of output A.
    logic               st_b;          // Waveform state of output B.
    logic               wave_a;        // Pin level A.
    logic               wave_b;        // Pin level B.
  } tcc_state_s;

  tcc_state_s s;
  tcc_state_s next_s;

  logic edge_evt;

  // Capture edges arrive from a pin and are synchronised before use.
  // (R09) Capture trigger source.
  tcc_edge_detect u_edge (
    .sys_clk    (sys_clk),
    .srst       (srst),
    .pin_in     (edge_input),
    .edge_sel   (edge_select_reg),
    .edge_pulse (edge_evt)
  );

  // Waveform state for a PWM-style output: restart sets active, match sets inactive.
  function automatic logic pwm_next(input logic cur, input logic restart, input logic hit);
    logic r;
    r = cur;
    if (restart) begin
      r = 1'b1;
    end
    if (hit) begin
      r = 1'b0;
    end
    return r;
  endfunction

  // Pin level from waveform state; a disabled pin shows the inverse of its level bit.
  function automatic logic pin_level(input logic en, input logic alv, input logic st);
    return en ? (st ^ alv) : ~alv;
  endfunction

  logic             tick;
  logic             start;
  logic             stop;
  logic             match_a;
  logic             match_p;
  logic             wrap;
  logic             restart;
  logic [1:0]       mode;

  // Event decode. Matches are looked at only in the cycle after the counter moved,
  // so a value held across eight system clocks raises one event, not eight.
  always_comb begin
    tick = (s.presc == PRESC_LAST);
    // (R20) Only a real change of the run bit counts.
    start = count_run & ~s.run_prev;
    stop  = ~count_run & s.run_prev;
    // (R06) Compare equality detect.
    // (R21) Single event per value.
    match_a = s.fresh & count_run & (s.counter == compare_a);
    match_p = s.fresh & count_run & (s.counter == compare_period);
    // (R18) Wrap at the maximum value.
    wrap = tick & ~s.clear_pend & count_run & (s.counter == CNT_MAX);
    restart = tick & s.clear_pend & s.clr_period;
    mode = {cfg.out_mode_hi, cfg.out_mode_lo};
  end

  // Next-state logic of the whole timer.
  always_comb begin
    next_s          = s;
    next_s.irq_a    = match_a;
    next_s.irq_p    = match_p;
    next_s.irq_cap  = 1'b0;
    next_s.fresh    = 1'b0;
    next_s.run_prev = count_run;

    // (R17) Divide by eight for the count clock.
    if (tick) begin
      next_s.presc = PRESC_RST;
    end else begin
      next_s.presc = s.presc + PRESC_W'(1);
    end

    if (tick) begin
      if (s.clear_pend) begin
        // (R01) Deferred clear lands on the tick.
        // (R04) Clear and start from zero at once.
        next_s.counter    = CNT_ZERO;
        next_s.clear_pend = 1'b0;
        next_s.clr_period = 1'b0;
        next_s.fresh      = count_run;
      end else if (count_run) begin
        // (R05) Counting resumes on the tick.
        next_s.counter = s.counter + CNT_ONE;
        next_s.fresh   = 1'b1;
      end
    end

    // (R02) Pending clear keeps the current value until the tick.
    // (R07) Period match schedules the clear.
    if (match_p && cfg.auto_clear_on_period) begin
      next_s.clear_pend = 1'b1;
      next_s.clr_period = 1'b1;
    end
    // (R03) Stop schedules a clear.
    // (R19) Start clears on the first tick.
    if (start || stop) begin
      next_s.clear_pend = 1'b1;
      next_s.clr_period = 1'b0;
    end

    // Set wins over a software clear arriving in the same cycle.
    // (R18) Sticky overflow flag.
    if (wrap) begin
      next_s.ovf_flag = 1'b1;
    end else if (overflow_clear) begin
      next_s.ovf_flag = 1'b0;
    end

    // A stopped timer takes no capture, since its count is not meaningful.
    // (R09) Capture latch.
    if (edge_evt && count_run) begin
      next_s.capture = s.counter;
      next_s.irq_cap = 1'b1;
    end

    // (R11) Output control from overflow and matches.
    // (R13) Mode selects waveform per pin.
    unique case (mode)
      MODE_TOGGLE: begin
        next_s.st_a = s.st_a ^ match_a;
        next_s.st_b = s.st_b ^ match_p;
      end
      MODE_PWM_A: begin
        next_s.st_a = pwm_next(s.st_a, wrap, match_a);
        next_s.st_b = s.st_b ^ match_p;
      end
      MODE_PWM_AB: begin
        next_s.st_a = pwm_next(s.st_a, wrap, match_a);
        next_s.st_b = pwm_next(s.st_b, wrap, match_p);
      end
      MODE_PPG_A: begin
        next_s.st_a = pwm_next(s.st_a, restart | wrap, match_a);
        next_s.st_b = s.st_b ^ match_p;
      end
    endcase

    // (R15) Enabled pin follows its waveform.
    // (R16) Disabled pin tied to inverse level bit.
    next_s.wave_a = pin_level(cfg.output_enable_a, cfg.active_level_a, next_s.st_a);
    next_s.wave_b = pin_level(cfg.output_enable_b, cfg.active_level_b, next_s.st_b);
  end

  // State register; reset stops the count and leaves the counter at zero.
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      s          <= '0;
      s.presc    <= PRESC_RST;
      s.counter  <= CNT_ZERO;
      s.capture  <= CAP_RST;
      s.wave_a   <= WAVE_RST;
      s.wave_b   <= WAVE_RST;
    end else begin
      s <= next_s;
    end
  end

  // All outputs come straight from flip-flops.
  assign main_counter     = s.counter;
  assign capture_value    = s.capture;
  assign overflow_flag    = s.ovf_flag;
  assign match_a_irq      = s.irq_a;
  assign match_period_irq = s.irq_p;
  assign capture_irq      = s.irq_cap;
  assign wave_out_a       = s.wave_a;
  assign wave_out_b       = s.wave_b;

endmodule

// ---- tb/tcc_pulse_src.sv ----
// Model of the external pulse source feeding the capture pin.
`timescale 1ns/100ps
module tcc_pulse_src (
  input  wire logic sys_clk, // System clock.
  output logic      pin      // Capture pin level.
);
  // The source always drives the pin, so it never floats; it starts low.
  initial pin = 1'b0;
  task automatic drive(input logic level);
    @(posedge sys_clk);
    pin <= level;
  endtask
endmodule

// ---- tb/tcc_timer16_assertions.sv ----
// Port-level assertions for the compare/capture timer.
`timescale 1ns/100ps
module tcc_timer16_assertions
  import tcc_pkg::*;
(
  input wire logic             sys_clk,          // System clock.
  input wire logic             srst,             // Synchronous reset.
  input wire logic             count_run,        // Run bit.
  input wire tcc_cfg_s         cfg,              // Output configuration.
  input wire logic [CNT_W-1:0] compare_a,        // Compare A value.
  input wire logic [CNT_W-1:0] compare_period,   // Period value.
  input wire logic             overflow_clear,   // Overflow flag clear.
  input wire logic [CNT_W-1:0] main_counter,     // Running count.
  input wire logic [CNT_W-1:0] capture_value,    // Captured count.
  input wire logic             overflow_flag,    // Sticky overflow.
  input wire logic             match_a_irq,      // Compare A pulse.
  input wire logic             match_period_irq, // Period pulse.
  input wire logic             capture_irq,      // Capture pulse.
  input wire logic             wave_out_a        // Output pin A.
);
  // One clock domain, so every check shares one clock and idles in reset.
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (srst);
  property p_hold; $changed(main_counter) |=> $stable(main_counter) [*7]; endproperty
  a_hold: assert property (p_hold) else $error("count moved between ticks");
  property p_step;
    $changed(main_counter) |-> main_counter == $past(main_counter) + 16'h0001
      || main_counter == CNT_ZERO;
  endproperty
  a_step: assert property (p_step) else $error("count jumped");
  property p_flag; overflow_flag && !overflow_clear |=> overflow_flag; endproperty
  a_flag: assert property (p_flag) else $error("overflow flag lost");
  property p_flag_set; $rose(overflow_flag) |-> main_counter == CNT_ZERO; endproperty
  a_flag_set: assert property (p_flag_set) else $error("flag set off wrap");
  property p_pulse_a; match_a_irq |=> !match_a_irq; endproperty
  a_pulse_a: assert property (p_pulse_a) else $error("match A pulse too long");
  property p_match_a; match_a_irq |-> main_counter == $past(compare_a); endproperty
  a_match_a: assert property (p_match_a) else $error("match A on wrong count");
  property p_match_p; match_period_irq |-> main_counter == $past(compare_period); endproperty
  a_match_p: assert property (p_match_p) else $error("period match wrong count");
  property p_stop; $fell(count_run) |-> ##[1:17] main_counter == CNT_ZERO; endproperty
  a_stop: assert property (p_stop) else $error("stop did not clear");
  property p_tied;
    $stable(cfg) [*3] ##0 !cfg.output_enable_a |-> wave_out_a == !cfg.active_level_a;
  endproperty
  a_tied: assert property (p_tied) else $error("disabled pin A level wrong");
  property p_cap_hold; !capture_irq |-> $stable(capture_value); endproperty
  a_cap_hold: assert property (p_cap_hold) else $error("capture changed unasked");
endmodule

bind tcc_timer16 tcc_timer16_assertions u_chk (
  .sys_clk(sys_clk), .srst(srst), .count_run(count_run), .cfg(cfg),
  .compare_a(compare_a), .compare_period(compare_period), .overflow_clear(overflow_clear),
  .main_counter(main_counter), .capture_value(capture_value), .overflow_flag(overflow_flag),
  .match_a_irq(match_a_irq), .match_period_irq(match_period_irq),
  .capture_irq(capture_irq), .wave_out_a(wave_out_a));

// ---- tb/testbench.sv ----
// Self-checking bench for the compare/capture timer.
`timescale 1ns/100ps
module testbench
  import tcc_pkg::*;
;
  logic             sys_clk = 1'b0, srst = 1'b1, count_run = 1'b0, overflow_clear = 1'b0;
  tcc_cfg_s         cfg = 7'h40;
  logic [CNT_W-1:0] compare_a = 16'h0003, compare_period = 16'h0005;
  tcc_edge_e        edge_sel = TCC_EDGE_RISE;
  logic [CNT_W-1:0] main_counter, capture_value, v;
  logic             edge_input, overflow_flag, match_a_irq, match_period_irq, capture_irq;
  logic             wave_out_a, wave_out_b, lvl;
  int               errors = 0, comparisons = 0, cyc = 0, n;

  // output pins are taken as routed to the timer function.
  tcc_timer16 DUT (
    .sys_clk(sys_clk), .srst(srst), .count_run(count_run), .cfg(cfg),
    .compare_a(compare_a), .compare_period(compare_period), .edge_select_reg(edge_sel),
    .edge_input(edge_input), .overflow_clear(overflow_clear), .main_counter(main_counter),
    .capture_value(capture_value), .overflow_flag(overflow_flag), .match_a_irq(match_a_irq),
    .match_period_irq(match_period_irq), .capture_irq(capture_irq), .wave_out_a(wave_out_a),
    .wave_out_b(wave_out_b));
  tcc_pulse_src SRC (.sys_clk(sys_clk), .pin(edge_input));

  // A 100 MHz clock.
  initial forever #5 sys_clk = ~sys_clk;
  // The whole run needs about 600 cycles, so 5000 means a hang.
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      errors = errors + 1;
      end_of_test();
    end
  end

  task automatic chk(input logic [CNT_W-1:0] got, input logic [CNT_W-1:0] exp);
    comparisons = comparisons + 1;
    if (got !== exp) begin
      errors = errors + 1;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  // Outputs are read at the falling edge, where they have settled.
  task automatic clk(input int k);
    repeat (k) @(negedge sys_clk);
  endtask
  // Returns at the falling edge, so no caller reads an output in its launching time step.
  task automatic set_run(input logic r);
    @(posedge sys_clk);
    count_run <= r;
    @(negedge sys_clk);
  endtask
  // Bounded wait for a count; n returns the cycles spent.
  task automatic wait_cnt(input logic [CNT_W-1:0] w);
    n = 0;
    while (main_counter !== w && n < 200) begin
      clk(1);
      n = n + 1;
    end
  endtask
  task automatic end_of_test();
    if (errors == 0 && comparisons > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // Main sequence: start, interval, stop and restart, capture, output modes.
  initial begin
    repeat (3) @(posedge sys_clk);
    srst <= 1'b0;
    set_run(1'b1);
    wait_cnt(16'h0001);
    wait_cnt(16'h0002);
    chk(16'(n), 16'h0008);
    wait_cnt(16'h0005);
    wait_cnt(16'h0000);
    chk(16'(n), 16'h0008);
    v = 16'h0000;
    repeat (48) begin
      clk(1);
      v = v + match_period_irq;
    end
    chk(v, 16'h0001);
    // Stop from a non-zero count so that the deferred clear is visible.
    wait_cnt(16'h0002);
    set_run(1'b0);
    clk(2);
    chk(main_counter, 16'h0002);
    clk(15);
    chk(main_counter, 16'h0000);
    clk(40);
    chk(main_counter, 16'h0000);
    set_run(1'b1);
    wait_cnt(16'h0001);
    chk(main_counter, 16'h0001);
    wait_cnt(16'h0003);
    set_run(1'b0);
    set_run(1'b1);
    wait_cnt(16'h0000);
    chk(16'(n < 17), 16'h0001);
    wait_cnt(16'h0001);
    chk(16'(n), 16'h0008);
    // Each edge selection against a rising and a falling pin edge, just after a tick.
    for (int i = 0; i < 8; i++) begin
      @(posedge sys_clk) edge_sel <= tcc_edge_e'(i / 2);
      clk(1);
      v = main_counter;
      while (main_counter === v) clk(1);
      v = main_counter;
      SRC.drive(!i[0]);
      n = 0;
      repeat (8) begin
        clk(1);
        if (capture_irq === 1'b1) n = 1;
      end
      chk(16'(n), 16'(i / 2 != i % 2));
      if (i / 2 != i % 2) chk(capture_value, v);
    end
    // only listed mode, clear and enable settings are used.
    // Each output mode, restarted so the count begins at a known phase.
    for (int m = 0; m < 4; m++) begin
      @(posedge sys_clk) cfg <= '{m == 3, m[1], m[0], 1'b1, 1'b0, 1'b1, 1'b0};
      set_run(1'b0);
      set_run(1'b1);
      wait_cnt(16'h0000);
      wait_cnt(16'h0001);
      lvl = wave_out_a;
      v = 16'(wave_out_b);
      n = 0;
      while (match_a_irq !== 1'b1 && n < 100) begin
        clk(1);
        n = n + 1;
      end
      clk(3);
      chk(wave_out_a, 16'(m == 0 ? !lvl : 1'b0));
      // Past the period match: toggle on B, or PWM B gone inactive.
      wait_cnt(m == 3 ? 16'h0000 : 16'h0006);
      chk(wave_out_b, 16'(m == 2 ? 1'b0 : !v[0]));
      if (m == 3) wait_cnt(16'h0001);
      if (m == 3) chk(wave_out_a, 16'h0001);
    end
    // Disabled pins sit at the inverse of their level bit.
    for (int k = 0; k < 2; k++) begin
      @(posedge sys_clk) cfg <= '{1'b1, 1'b0, 1'b0, 1'b0, k[0], 1'b0, !k[0]};
      overflow_clear <= k[0];
      clk(3);
      chk(wave_out_a, 16'(!k[0]));
      chk(wave_out_b, 16'(k[0]));
      chk(overflow_flag, 16'h0000);
    end
    end_of_test();
  end
endmodule
